// file: design/fls_regs.svh
// Purpose: offsets, field positions, command codes and timing counts
// Assumes: 25 MHz system clock
// Notes:   times are in their own unit, cycle counts derive from them
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH
// register window offsets and fields
`define FLS_OFS_MAIN_LOCK  8'hc0
`define FLS_OFS_SEC_LOCK   8'hc2
`define FLS_SECURITY_BIT   7
// instruction unlock cycles, upper address nibble ignored
`define FLS_UNLK1_ADDR     12'h555
`define FLS_UNLK2_ADDR     12'haaa
`define FLS_UNLK1_DATA     8'haa
`define FLS_UNLK2_DATA     8'h55
// command bytes
`define FLS_CMD_AUTOSEL    8'h90
`define FLS_CMD_PROG       8'ha0
`define FLS_CMD_ERASE      8'h80
`define FLS_CMD_SECTOR     8'h30
`define FLS_CMD_CHIP       8'h10
`define FLS_CMD_SUSPEND    8'hb0
`define FLS_CMD_RESUME     8'h30
`define FLS_CMD_RESET      8'hf0
`define FLS_CMD_GUARD_OFF  8'h20
// identifier reads, address bits a6,a1,a0
`define FLS_ID_SEL         3'b001
`define FLS_PROT_SEL       3'b010
`define FLS_ERASED         8'hff
// timing
`define FLS_CLK_KHZ        25000
`define FLS_POWERUP_MS     5
`define FLS_GAP_US         80
`define FLS_PROG_US        14
`define FLS_EEWR_US        200
`define FLS_EEGAP_US       100
`define FLS_GAP_CYC        (`FLS_GAP_US * `FLS_CLK_KHZ / 1000)
`define FLS_PROG_CYC       (`FLS_PROG_US * `FLS_CLK_KHZ / 1000)
`define FLS_EEGAP_CYC      (`FLS_EEGAP_US * `FLS_CLK_KHZ / 1000)
`endif

// file: design/fls_pkg.sv
// Purpose: state types of the flash and eeprom sequencers
// Assumes: nothing
// Notes:   one-hot codes
package fls_pkg;
  typedef enum logic [10:0] {
    FS_READ    = 11'h001,  // normal read array
    FS_GOT_AA  = 11'h002,  // first unlock seen
    FS_GOT_55  = 11'h004,  // second unlock seen, awaiting command
    FS_ER_AA   = 11'h008,  // erase setup, awaiting unlock
    FS_ER_55   = 11'h010,
    FS_ER_CMD  = 11'h020,  // awaiting sector or chip confirm
    FS_PROG_DT = 11'h040,  // awaiting program data
    FS_AUTOSEL = 11'h080,  // identifier reads
    FS_PROGRAM = 11'h100,
    FS_ERASE   = 11'h200,
    FS_SUSPEND = 11'h400
  } fls_state_t;
  typedef enum logic [6:0] {
    ES_IDLE = 7'h01,
    ES_AA   = 7'h02,
    ES_55   = 7'h04,
    ES_80   = 7'h08,
    ES_AA2  = 7'h10,
    ES_552  = 7'h20,
    ES_GWR  = 7'h40        // guarded write stream
  } fls_ee_state_t;
endpackage

// file: design/fls_timer.sv
// Purpose: retriggerable one-shot counter
// Assumes: start is a one-cycle pulse
// Notes:   done pulses in the cycle the count runs out
`timescale 1ns/1ps
module fls_timer #(
  parameter int W   = 17,
  parameter int CYC = 100
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic start,   // reload, also while running
  output logic      run,     // count in progress
  output logic      done     // last cycle of the count
);
  logic [W-1:0] cnt;         // cycles left

  // load or count down
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= W'(CYC);
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign run  = (cnt != '0);
  assign done = (cnt == W'(1)) && !start;
endmodule

// file: design/fls_sel_enc.sv
// Purpose: turn one-hot sector selects into an index
// Assumes: at most one select active
// Notes:   lowest active wins if several are driven
`timescale 1ns/1ps
module fls_sel_enc #(
  parameter int N = 8,
  parameter int W = 3
) (
  input  wire logic [N-1:0] sel,  // sector selects
  output logic              any,  // some sector selected
  output logic [W-1:0]      idx   // index of the selected sector
);
  // priority scan from the top so the lowest index lands last
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel[i]) begin
        idx = W'(i);
      end
    end
  end

  assign any = |sel;
endmodule

// file: design/fls_access.sv
// Purpose: read, program, erase and eeprom write sequencing
// Assumes: bus strobes and selects share sys_clk
// Notes:   erase is a walk writing erased bytes, one per cycle
`timescale 1ns/1ps
`include "fls_regs.svh"
module fls_access
  import fls_pkg::*;
#(
  parameter bit       SEC_IS_EEPROM = 1'b1,   // secondary is eeprom, else boot flash
  parameter bit       GUARD_AT_RESET = 1'b0,  // eeprom write guard after reset
  parameter logic [7:0] FLASH_ID    = 8'h5a,  // arbitrary identifier value
  parameter int       POWERUP_CYC   = `FLS_POWERUP_MS * `FLS_CLK_KHZ,
  parameter int       EEWR_CYC      = `FLS_EEWR_US * `FLS_CLK_KHZ / 1000
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [7:0]       bus_rdata,
  output logic             bus_rvalid,
  input  wire logic [7:0]  main_sector_select,
  input  wire logic [3:0]  eeprom_sector_select,
  input  wire logic [3:0]  boot_sector_select,
  input  wire logic        register_space_select,
  input  wire logic [7:0]  main_lock,
  input  wire logic [3:0]  sec_lock,
  input  wire logic        security_on,
  input  wire logic        port_c_bit3_rdy_en,
  output logic             ready_busy,
  output logic             port_c_bit3_out,
  output logic             port_c_bit3_oe
);
  logic [7:0]  main_mem [0:131071];  // eight 16 KB sectors
  logic [7:0]  sec_mem  [0:32767];   // four 8 KB sectors
  fls_state_t    fs;                 // flash sequencer
  fls_ee_state_t es;                 // eeprom sequencer
  logic        m_any, s_any;         // decoded selects
  logic [2:0]  m_idx;
  logic [1:0]  s_idx;
  logic [3:0]  sec_sel;
  logic        f_hit, e_hit;         // access aims at flash or eeprom
  logic        fw, ew;               // write strobes per path
  logic        unlk1, unlk2, at555;  // unlock pattern matches
  logic        cur_locked;           // lock of the addressed sector
  logic [16:0] cur_addr;             // array index of this access
  logic        tgt_sec;              // program target in secondary
  logic [16:0] tgt_addr;
  logic [7:0]  prog_data;
  logic        prog_go;              // one-cycle array update
  logic [16:0] er_addr, er_last;     // erase walk
  logic        er_sec, er_chip;
  logic        guard;                // eeprom write guard
  logic        ee_gather;            // write event collecting bytes
  logic [8:0]  ee_page;              // page of the open event
  logic [7:0]  ee_last;              // last byte, for polling
  logic        ee_store;             // byte goes into eeprom
  logic        ee_plain, ee_take;
  logic        pu_arm;
  logic        lockout;
  logic        pu_run, fgap_run, fgap_done, prog_run, prog_done;
  logic        egap_done, gath_done, ewr_run;
  logic        fgap_start, egap_start;

  fls_sel_enc #(.N(8), .W(3)) u_main_enc (
    .sel (main_sector_select),
    .any (m_any),
    .idx (m_idx)
  );
  fls_sel_enc #(.N(4), .W(2)) u_sec_enc (
    .sel (sec_sel),
    .any (s_any),
    .idx (s_idx)
  );

  // selects come straight from the decode array
  // product terms and space remapping live there
  assign sec_sel = SEC_IS_EEPROM ? eeprom_sector_select : boot_sector_select;
  assign f_hit   = m_any || (!SEC_IS_EEPROM && s_any);
  assign e_hit   = SEC_IS_EEPROM && s_any && !m_any;
  assign fw      = bus_wr && f_hit && !register_space_select;
  assign ew      = bus_wr && e_hit && !register_space_select;
  // upper nibble ignored in unlock cycles
  assign at555   = (bus_addr[11:0] == `FLS_UNLK1_ADDR);
  assign unlk1   = at555 && (bus_wdata == `FLS_UNLK1_DATA);
  assign unlk2   = (bus_addr[11:0] == `FLS_UNLK2_ADDR) && (bus_wdata == `FLS_UNLK2_DATA);
  assign cur_locked = m_any ? main_lock[m_idx] : sec_lock[s_idx];
  assign cur_addr   = m_any ? {m_idx, bus_addr[13:0]} : {2'b00, s_idx, bus_addr[12:0]};

  // power-up lockout: counter armed in the first cycle after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pu_arm <= 1'b0;
    end else begin
      pu_arm <= 1'b1;
    end
  end
  assign lockout = !pu_arm || pu_run;

  fls_timer #(.W(17), .CYC(POWERUP_CYC)) u_pu (
    .sys_clk (sys_clk), .rstn (rstn), .start (!pu_arm), .run (pu_run), .done ()
  );
  fls_timer #(.W(12), .CYC(`FLS_GAP_CYC)) u_fgap (
    .sys_clk (sys_clk), .rstn (rstn), .start (fgap_start),
    .run (fgap_run), .done (fgap_done)
  );
  fls_timer #(.W(12), .CYC(`FLS_PROG_CYC)) u_prog (
    .sys_clk (sys_clk), .rstn (rstn), .start (prog_go), .run (prog_run), .done (prog_done)
  );
  fls_timer #(.W(12), .CYC(`FLS_GAP_CYC)) u_egap (
    .sys_clk (sys_clk), .rstn (rstn), .start (egap_start), .run (), .done (egap_done)
  );
  fls_timer #(.W(12), .CYC(`FLS_EEGAP_CYC)) u_gath (
    .sys_clk (sys_clk), .rstn (rstn), .start (ee_store), .run (), .done (gath_done)
  );
  fls_timer #(.W(13), .CYC(EEWR_CYC)) u_ewr (
    .sys_clk (sys_clk), .rstn (rstn), .start (gath_done), .run (ewr_run), .done ()
  );

  // gap timer restarts on every flash sequence byte
  assign fgap_start = fw && (fs != FS_PROGRAM) && (fs != FS_ERASE) && (fs != FS_SUSPEND);

  // flash instruction decoder and operation control
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fs        <= FS_READ;
      tgt_sec   <= 1'b0;
      tgt_addr  <= '0;
      prog_data <= '0;
      prog_go   <= 1'b0;
      er_addr   <= '0;
      er_last   <= '0;
      er_sec    <= 1'b0;
      er_chip   <= 1'b0;
    end else begin
      prog_go <= 1'b0;
      if (fw) begin
        unique case (fs)
          FS_READ:    if (unlk1) fs <= FS_GOT_AA;  // plain write ignored
          FS_GOT_AA:  fs <= unlk2 ? FS_GOT_55 : FS_READ;
          FS_GOT_55: begin
            if (bus_wdata == `FLS_CMD_RESET) fs <= FS_READ;
            else if (at555 && bus_wdata == `FLS_CMD_AUTOSEL) fs <= FS_AUTOSEL;
            else if (at555 && bus_wdata == `FLS_CMD_PROG) fs <= FS_PROG_DT;
            else if (at555 && bus_wdata == `FLS_CMD_ERASE) fs <= FS_ER_AA;
            else fs <= FS_READ;
          end
          FS_ER_AA:   fs <= unlk1 ? FS_ER_55 : FS_READ;
          FS_ER_55:   fs <= unlk2 ? FS_ER_CMD : FS_READ;
          FS_ER_CMD: begin
            if (bus_wdata == `FLS_CMD_SECTOR && !cur_locked) begin
              // whole sector at a time
              fs      <= FS_ERASE;
              er_chip <= 1'b0;
              er_sec  <= !m_any;
              er_addr <= m_any ? {m_idx, 14'h0000} : {2'b00, s_idx, 13'h0000};
              er_last <= m_any ? {m_idx, 14'h3fff} : {2'b00, s_idx, 13'h1fff};
            end else if (at555 && bus_wdata == `FLS_CMD_CHIP) begin
              fs      <= FS_ERASE;
              er_chip <= 1'b1;
              er_sec  <= 1'b0;
              er_addr <= '0;
              er_last <= 17'h1ffff;
            end else begin
              fs <= FS_READ;  // locked or bad confirm
            end
          end
          FS_PROG_DT: begin
            if (cur_locked) begin
              fs <= FS_READ;
            end else begin
              // one byte per instruction
              fs        <= FS_PROGRAM;
              tgt_sec   <= !m_any;
              tgt_addr  <= cur_addr;
              prog_data <= bus_wdata;
              prog_go   <= 1'b1;
            end
          end
          FS_AUTOSEL: if (bus_wdata == `FLS_CMD_RESET) fs <= FS_READ;
          FS_PROGRAM: ;  // writes ignored while programming
          FS_ERASE:   if (bus_wdata == `FLS_CMD_SUSPEND) fs <= FS_SUSPEND;
          FS_SUSPEND: if (bus_wdata == `FLS_CMD_RESUME) fs <= FS_ERASE;
        endcase
      end else if (fgap_done && !(fs inside {FS_READ, FS_AUTOSEL, FS_PROGRAM,
                                             FS_ERASE, FS_SUSPEND})) begin
        fs <= FS_READ;  // byte gap too long
      end else if (fs == FS_PROGRAM && prog_done) begin
        fs <= FS_READ;
      end else if (fs == FS_ERASE) begin
        // walk pauses in suspend, carries on from here on resume
        if (er_addr == er_last) fs <= FS_READ;
        else er_addr <= er_addr + 17'h00001;
      end
    end
  end

  // main array updates: program clears bits, erase walk sets them
  always_ff @(posedge sys_clk) begin
    if (prog_go && !tgt_sec) begin
      main_mem[tgt_addr] <= main_mem[tgt_addr] & prog_data;
    end
    if (fs == FS_ERASE && !er_sec && !(er_chip && main_lock[er_addr[16:14]])) begin
      main_mem[er_addr] <= `FLS_ERASED;  // chip erase skips locked
    end
  end

  // eeprom byte acceptance: locked out at power-up and while writing
  assign ee_take  = ew && !lockout && !ewr_run;
  assign ee_plain = ee_take && !guard && !(es == ES_GWR);
  // a process, not an assign: the match function reads bus lines directly
  always_comb begin
    ee_store = ee_take && !sec_lock[s_idx]
               && (!ee_gather || ee_page == {s_idx, bus_addr[12:6]})
               && ((es == ES_GWR) || (ee_plain && !ee_seq_match(es)));
  end
  assign egap_start = ee_take;

  // does this byte continue the current eeprom instruction
  function automatic logic ee_seq_match(input fls_ee_state_t s);
    unique case (s)
      ES_IDLE: ee_seq_match = unlk1;
      ES_AA:   ee_seq_match = unlk2;
      ES_55:   ee_seq_match = at555 && (bus_wdata == `FLS_CMD_PROG
                                        || bus_wdata == `FLS_CMD_ERASE);
      ES_80:   ee_seq_match = unlk1;
      ES_AA2:  ee_seq_match = unlk2;
      ES_552:  ee_seq_match = at555 && bus_wdata == `FLS_CMD_GUARD_OFF;
      ES_GWR:  ee_seq_match = 1'b1;
    endcase
  endfunction

  // eeprom instruction decoder and guard
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      es    <= ES_IDLE;
      guard <= GUARD_AT_RESET;
    end else if (ee_take) begin
      if (!ee_seq_match(es)) begin
        es <= ES_IDLE;  // offending byte handled as plain write
      end else begin
        unique case (es)
          ES_IDLE: es <= ES_AA;
          ES_AA:   es <= ES_55;
          ES_55: begin
            if (bus_wdata == `FLS_CMD_PROG) begin
              es    <= ES_GWR;
              guard <= 1'b1;
            end else begin
              es <= ES_80;
            end
          end
          ES_80:   es <= ES_AA2;
          ES_AA2:  es <= ES_552;
          ES_552: begin
            es    <= ES_IDLE;
            guard <= 1'b0;
          end
          ES_GWR:  es <= ES_GWR;
        endcase
      end
    end else if (es == ES_GWR ? gath_done : egap_done) begin
      es <= ES_IDLE;  // stream closed or instruction timed out
    end
  end

  // write event grouping within one 64-byte page
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ee_gather <= 1'b0;
      ee_page   <= '0;
      ee_last   <= '0;
    end else if (ee_store) begin
      ee_gather <= 1'b1;
      ee_page   <= {s_idx, bus_addr[12:6]};
      ee_last   <= bus_wdata;
    end else if (gath_done) begin
      ee_gather <= 1'b0;
    end
  end

  // secondary array: eeprom bytes overwrite, erase is implied
  always_ff @(posedge sys_clk) begin
    if (ee_store) begin
      sec_mem[cur_addr[14:0]] <= bus_wdata;
    end
    if (prog_go && tgt_sec) begin
      sec_mem[tgt_addr[14:0]] <= sec_mem[tgt_addr[14:0]] & prog_data;
    end
    if (fs == FS_ERASE && er_sec) begin
      sec_mem[er_addr[14:0]] <= `FLS_ERASED;
    end
  end

  // read path: register window, flash, eeprom
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_rdata  <= '0;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_rd;
      if (!bus_rd) begin
        bus_rdata <= bus_rdata;
      end else if (register_space_select) begin
        // 256-byte window, base placed outside
        unique case (bus_addr[7:0])
          `FLS_OFS_MAIN_LOCK: bus_rdata <= main_lock;
          `FLS_OFS_SEC_LOCK: begin
            bus_rdata <= {4'h0, sec_lock};
            bus_rdata[`FLS_SECURITY_BIT] <= security_on;
          end
          default: bus_rdata <= 8'h00;  // unimplemented offsets
        endcase
      end else if (f_hit) begin
        if (fs == FS_PROGRAM) begin
          bus_rdata <= {~prog_data[7], 7'h00};  // polling status
        end else if (fs == FS_ERASE) begin
          bus_rdata <= 8'h00;  // erased data complement
        end else if (fs == FS_AUTOSEL) begin
          if ({bus_addr[6], bus_addr[1:0]} == `FLS_ID_SEL) bus_rdata <= FLASH_ID;
          else if ({bus_addr[6], bus_addr[1:0]} == `FLS_PROT_SEL) bus_rdata <= {7'h00, cur_locked};
          else bus_rdata <= 8'h00;
        end else if (m_any) begin
          bus_rdata <= main_mem[cur_addr];
        end else begin
          bus_rdata <= sec_mem[cur_addr[14:0]];
        end
      end else if (e_hit) begin
        if (ee_gather || ewr_run) bus_rdata <= {~ee_last[7], 7'h00};
        else bus_rdata <= sec_mem[cur_addr[14:0]];
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end

  // ready/busy, registered; suspended erase counts as ready
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ready_busy <= 1'b1;
    end else begin
      ready_busy <= !((fs == FS_PROGRAM) || (fs == FS_ERASE) || ee_gather || ewr_run);
    end
  end

  assign port_c_bit3_out = ready_busy;
  assign port_c_bit3_oe  = port_c_bit3_rdy_en;
endmodule

// file: tb/fls_access_chk.sv
// Purpose: port checks of the flash access block
// Assumes: one clock, sync active-low reset
// Notes:   lockout is counted from reset release
`timescale 1ns/1ps
module fls_access_chk #(
  parameter int POWERUP_CYC = 50
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_rvalid,
  input wire logic [7:0]  main_sector_select,
  input wire logic [3:0]  eeprom_sector_select,
  input wire logic        register_space_select,
  input wire logic [7:0]  main_lock,
  input wire logic [3:0]  sec_lock,
  input wire logic        security_on,
  input wire logic        port_c_bit3_rdy_en,
  input wire logic        ready_busy,
  input wire logic        port_c_bit3_out,
  input wire logic        port_c_bit3_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] up_cnt;  // cycles since reset release
  logic        ee_wr;   // plain write aimed at eeprom only
  logic        reg_rd;  // read inside the register window
  assign ee_wr  = bus_wr && (|eeprom_sector_select) && !(|main_sector_select)
    && !register_space_select;
  assign reg_rd = bus_rd && register_space_select;
  // saturating, so a long run never wraps back into the lockout
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      up_cnt <= 32'h0;
    end else if (up_cnt != 32'hffffffff) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end
  AST_RVALID: assert property (bus_rvalid == $past(bus_rd))
    else $error("read answer not one cycle after read");
  AST_HOLD: assert property (!bus_rvalid |-> $stable(bus_rdata))
    else $error("read data moved without an answer");
  AST_C0: assert property (reg_rd && bus_addr[7:0] == 8'hc0
    |=> bus_rdata == $past(main_lock)) else $error("main lock register wrong");
  AST_C2: assert property (reg_rd && bus_addr[7:0] == 8'hc2
    |=> bus_rdata == {$past(security_on), 3'h0, $past(sec_lock)})
    else $error("security register wrong");
  AST_OTHER: assert property (reg_rd && bus_addr[7:0] != 8'hc0
    && bus_addr[7:0] != 8'hc2 |=> bus_rdata == 8'h00) else $error("unmapped offset not zero");
  AST_PC3: assert property (port_c_bit3_oe == port_c_bit3_rdy_en
    && (!port_c_bit3_rdy_en || port_c_bit3_out == ready_busy)) else $error("status pin wrong");
  AST_FELL: assert property ($fell(ready_busy)
    |-> $past(bus_wr) || $past(bus_wr, 2)) else $error("busy without a write");
  AST_LOCKOUT: assert property (up_cnt < POWERUP_CYC && ee_wr
    && ready_busy && !$past(bus_wr) |=> ready_busy [*2]) else $error("eeprom write in lockout");
  cover property (reg_rd);
  cover property ($fell(ready_busy));
  cover property (ee_wr && up_cnt < POWERUP_CYC);
endmodule

// file: tb/fls_host_mdl.sv
// Purpose: host bus model issuing byte reads and writes
// Assumes: strobes are sampled on the rising edge
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module fls_host_mdl (
  input  wire logic       sys_clk,
  input  wire logic       bus_rvalid,
  input  wire logic [7:0] bus_rdata,
  output logic [15:0]     bus_addr,
  output logic [7:0]      bus_wdata,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic [12:0]     sel       // {register, eeprom[3:0], main[7:0]}
);
  initial begin
    bus_addr  = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    sel       = 13'h0000;
  end
  // one byte write, strobe held over exactly one sampling edge
  task automatic wr(input logic [12:0] s, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sel       <= s;
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
    sel       <= 13'h0000;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask
  // one byte read, answer taken in the cycle after the taking edge
  task automatic rd(input logic [12:0] s, input logic [15:0] a,
                    output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    sel      <= s;
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    sel      <= 13'h0000;
    bus_addr <= ~a;
    @(posedge sys_clk);
    d = bus_rdata;
    v = bus_rvalid;
  endtask
endmodule

// file: tb/tb_fls_access.sv
// Purpose: sequences of bus calls against the flash access block
// Assumes: 25 MHz clock, lockout and write time shortened
// Notes:   array contents start unknown, so only written places are read
`timescale 1ns/1ps
module tb_fls_access;
  localparam int          PUP = 50;       // shortened lockout
  localparam int          EEW = 20;       // shortened eeprom write time
  localparam logic [7:0]  ID  = 8'h5a;    // arbitrary identifier value
  localparam logic [12:0] RG = 13'h1000, EE0 = 13'h0100, M1 = 13'h0002;
  logic sys_clk = 1'b0, rstn = 1'b0, security_on = 1'b1, pc3_en = 1'b1;
  logic [7:0]  main_lock = 8'h80;  // only sector 7 locked at first
  logic [3:0]  sec_lock  = 4'ha;   // eeprom sector 0 stays open
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [12:0] sel;
  logic        bus_wr, bus_rd, bus_rvalid, ready_busy, pc3_out, pc3_oe;
  int          fail_count = 0, compares = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  fls_host_mdl h (.sys_clk(sys_clk), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .sel(sel));
  fls_access #(.FLASH_ID(ID), .POWERUP_CYC(PUP), .EEWR_CYC(EEW)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .main_sector_select(sel[7:0]), .eeprom_sector_select(sel[11:8]),
    .boot_sector_select(4'h0), .register_space_select(sel[12]), .main_lock(main_lock),
    .sec_lock(sec_lock), .security_on(security_on), .port_c_bit3_rdy_en(pc3_en),
    .ready_busy(ready_busy), .port_c_bit3_out(pc3_out), .port_c_bit3_oe(pc3_oe));
  task automatic close_out();
    $display("checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // read and compare; a missing answer never matches
  task automatic rc(input logic [12:0] s, input logic [15:0] a, input logic [7:0] e,
                    input string m);
    logic [7:0] d;
    logic       v;
    h.rd(s, a, d, v);
    chk((v === 1'b1) ? d : ~e, e, m);
  endtask
  // unlock pair then command, upper address nibble set to show it is ignored
  task automatic cmd(input logic [12:0] s, input logic [7:0] c);
    h.wr(s, 16'h5555, 8'haa);
    h.wr(s, 16'h5aaa, 8'h55);
    h.wr(s, 16'h5555, c);
  endtask
  // status two edges after a write; the port pin output enable is checked too
  task automatic bz(input logic e, input string m);
    repeat (2) @(posedge sys_clk);
    chk({6'h0, pc3_oe, ready_busy}, {6'h0, 1'b1, e}, m);
  endtask
  // bounded poll of the status output
  task automatic rdy(input int n, input string m);
    int i;
    repeat (2) @(posedge sys_clk);  // busy shows only two edges after the last byte
    for (i = 0; i < n && ready_busy !== 1'b1; i++) @(posedge sys_clk);
    chk({7'h0, ready_busy}, 8'h01, m);
  endtask
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    h.wr(EE0, 16'h8010, 8'h11);
    bz(1'b1, "lockout");
    rc(RG, 16'h12c0, 8'h80, "c0");
    rc(RG, 16'h00c2, 8'h8a, "c2");
    h.wr(RG, 16'h00c0, 8'h00);
    rc(RG, 16'h00c0, 8'h80, "c0 read only");
    rc(RG, 16'h00c4, 8'h00, "unmapped");
    repeat (PUP) @(posedge sys_clk);
    // two bytes of one page make a single write event
    h.wr(EE0, 16'h8021, 8'h16);
    h.wr(EE0, 16'h8022, 8'h69);
    bz(1'b0, "ee busy");
    rc(EE0, 16'h8022, 8'h80, "ee status");
    rdy(2500 + EEW + 200, "ee done");
    rc(EE0, 16'h8021, 8'h16, "ee byte a");
    rc(EE0, 16'h8022, 8'h69, "ee byte b");
    cmd(EE0, 8'ha0);
    h.wr(EE0, 16'h8030, 8'h3c);
    rdy(2500 + EEW + 200, "guarded");
    h.wr(EE0, 16'h8030, 8'hc3);
    bz(1'b1, "guard refuses");
    rc(EE0, 16'h8030, 8'h3c, "guard kept");
    cmd(EE0, 8'h80);
    cmd(EE0, 8'h20);
    h.wr(EE0, 16'h8030, 8'h5a);
    rdy(2500 + EEW + 200, "unguarded");
    rc(EE0, 16'h8030, 8'h5a, "guard off");
    // broken instruction: the mismatching byte lands as a plain write
    h.wr(EE0, 16'h8555, 8'haa);
    h.wr(EE0, 16'h8040, 8'h77);
    rdy(2500 + EEW + 200, "offending byte");
    rc(EE0, 16'h8040, 8'h77, "offending byte stored");
    // sector erase, suspended and read elsewhere, then resumed
    cmd(M1, 8'h80);
    cmd(M1, 8'h30);
    bz(1'b0, "erasing");
    repeat (1000) @(posedge sys_clk);
    h.wr(M1, 16'h4000, 8'hb0);
    bz(1'b1, "suspended");
    rc(EE0, 16'h8030, 8'h5a, "other sector");
    h.wr(M1, 16'h4000, 8'h30);
    bz(1'b0, "resumed");
    rdy(17000, "erase done");
    rc(M1, 16'h4abc, 8'hff, "erased");
    h.wr(M1, 16'h4000, 8'hb0);
    bz(1'b1, "idle suspend");
    cmd(M1, 8'ha0);
    h.wr(M1, 16'h4abc, 8'h3c);
    bz(1'b0, "programming");
    rc(M1, 16'h4abc, 8'h80, "program status");
    rdy(400, "program done");
    rc(M1, 16'h4abc, 8'h3c, "programmed");
    h.wr(M1, 16'h4abc, 8'h00);
    rc(M1, 16'h4abc, 8'h3c, "plain write");
    // gap past the 2000-cycle limit drops the unlock, so no program starts
    h.wr(M1, 16'h5555, 8'haa);
    repeat (2100) @(posedge sys_clk);
    h.wr(M1, 16'h5aaa, 8'h55);
    h.wr(M1, 16'h5555, 8'ha0);
    h.wr(M1, 16'h4abc, 8'h00);
    bz(1'b1, "gap timeout");
    @(posedge sys_clk);
    main_lock <= 8'h82;
    cmd(M1, 8'ha0);
    h.wr(M1, 16'h4abc, 8'h00);
    bz(1'b1, "locked");
    rc(M1, 16'h4abc, 8'h3c, "lock kept");
    cmd(M1, 8'h90);
    rc(M1, 16'h4001, ID, "identifier");
    rc(M1, 16'h4002, 8'h01, "protection");
    h.wr(M1, 16'h4000, 8'hf0);
    h.wr(M1, 16'h5555, 8'haa);
    h.wr(M1, 16'h5aaa, 8'h12);
    rc(M1, 16'h4abc, 8'h3c, "back to read");
    close_out();
  end
endmodule
bind fls_access fls_access_chk #(.POWERUP_CYC(POWERUP_CYC)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
  .main_sector_select(main_sector_select), .eeprom_sector_select(eeprom_sector_select),
  .register_space_select(register_space_select), .main_lock(main_lock),
  .sec_lock(sec_lock), .security_on(security_on), .port_c_bit3_rdy_en(port_c_bit3_rdy_en),
  .ready_busy(ready_busy), .port_c_bit3_out(port_c_bit3_out),
  .port_c_bit3_oe(port_c_bit3_oe));
